// *** inc/cfg_regs_pkg.sv ***
// Package: offsets, field positions, resets and types for the sync and mode
// configuration register bank. Assumes a 32-bit APB master and one clock.
// Functional notes
// - Six per-group sync exclude bits, groups 3,4 excluded
// - Sync pin output selector resets to logic low
// - Qualify bit gates sync by running clock
// - Sync pin input polarity resets active low
// - Auto-sync clear: group writes start no sync
// - Lock pin selector resets to both-loop lock
// - Hold sync until loop two locks
// - Hold sync until loop one locks
// - Tracking enable resets set
// - Holdover mode field resets to enabled
// - Ignore loop one lock falling edge
// - Reference select mode resets to manual
// - Status pin input invert resets active high
// - Three reference usable bits, all set
// - Loss timeout field resets to 1200 ns
// - Two status pin selectors reset low
// - Crystal oscillator enable resets off
// - Reset bit restores every default
package cfg_regs_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_CTRL0     = 8'h00;
	localparam logic [7:0] IDX_SYNC_MODE = 8'h0b;
	localparam logic [7:0] IDX_LOCK_HOLD = 8'h0c;
	localparam logic [7:0] IDX_HOLD_SEL  = 8'h0d;
	localparam logic [7:0] IDX_LOSS      = 8'h0e;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
	localparam logic [7:0] IDX_SYNC_CMD  = 8'h22;
	localparam logic [7:0] IDX_STATE     = 8'h23;

	// Field positions
	localparam int POS_SOFT_RESET   = 17;
	localparam int POS_GRP_EXCL_LO  = 20;
	localparam int POS_SYNC_OUT_SEL = 18;
	localparam int POS_SYNC_QUALIFY_ENABLE    = 17;
	localparam int POS_SYNC_POL     = 16;
	localparam int POS_SYNC_AUTO    = 15;
	localparam int POS_XTAL_EN      = 5;
	localparam int POS_LOCK_SEL     = 27;
	localparam int POS_HOLD_L2      = 23;
	localparam int POS_HOLD_L1      = 22;
	localparam int POS_TRACK        = 8;
	localparam int POS_HOLD_MODE    = 6;
	localparam int POS_STAT1_SEL    = 20;
	localparam int POS_EDGE_IGN     = 15;
	localparam int POS_STAT0_SEL    = 12;
	localparam int POS_REF_MODE     = 9;
	localparam int POS_STAT_INV     = 8;
	localparam int POS_REF_USE_LO   = 5;
	localparam int POS_LOSS_TO      = 30;

	// Reset values of the four configuration words
	localparam logic [31:0] RST_SYNC_MODE = 32'h0581_1000;
	localparam logic [31:0] RST_LOCK_HOLD = 32'h1b00_0180;
	localparam logic [31:0] RST_HOLD_SEL  = 32'h3b02_06e0;
	localparam logic [31:0] RST_LOSS      = 32'h1200_0000;
	// Writable bits of each word
	localparam logic [31:0] WM_SYNC_MODE  = 32'h03ff_8020;
	localparam logic [31:0] WM_LOCK_HOLD  = 32'hf8c0_01c0;
	localparam logic [31:0] WM_HOLD_SEL   = 32'h0070_ffe0;
	localparam logic [31:0] WM_LOSS       = 32'hc000_0000;

	// Loss timeout codes; code 0 is 1200 ns
	localparam int LOSS_T0_NS = 1200;
	localparam int LOSS_T1_NS = 206;
	localparam int LOSS_T2_NS = 52;
	localparam int LOSS_T3_NS = 23;
	localparam int CLK_NS     = 8;
	localparam logic [7:0] LOSS_C0 = 8'((LOSS_T0_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] LOSS_C1 = 8'((LOSS_T1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] LOSS_C2 = 8'((LOSS_T2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] LOSS_C3 = 8'((LOSS_T3_NS + CLK_NS - 1) / CLK_NS);

	// Interrupt bit positions
	localparam int IRQ_SYNC_DONE = 0;
	localparam int IRQ_HOLD_IN   = 1;
	localparam int IRQ_LOSS      = 2;
	localparam int IRQ_W         = 3;

	localparam logic [1:0] HOLD_MODE_EN = 2'h2;

	typedef struct packed {
		logic [5:0] grp_excl;
		logic [1:0] sync_out_sel;
		logic       sync_qualify_enable;
		logic       sync_pol;
		logic       sync_auto;
		logic       xtal_en;
		logic [4:0] lock_sel;
		logic       hold_l2;
		logic       hold_l1;
		logic       track_en;
		logic [1:0] hold_mode;
		logic [2:0] stat1_sel;
		logic       edge_ign;
		logic [2:0] stat0_sel;
		logic [2:0] ref_mode;
		logic       stat_inv;
		logic [2:0] ref_usable;
		logic [1:0] loss_to;
	} cfg_t;

	typedef struct packed {
		logic       sync_pin;
		logic       lock_pin;
		logic       stat0_pin;
		logic       stat1_pin;
	} pins_t;

endpackage

// *** hw/sync_holdover_mode_ctrl_regs.sv ***
// Register bank for sync, lock pin, holdover and reference selection control,
// plus the small sync, holdover and loss logic these fields steer.
// Assumes an APB master on core_clk and status inputs synchronous to it.
//
// Chosen here: the APB interface to the registers.
module sync_holdover_mode_ctrl_regs (
	input  wire logic        core_clk,      // 125 MHz clock
	input  wire logic        sys_rst,       // Synchronous reset, high
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB write
	input  wire logic [9:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error, unmapped address
	input  wire logic        sync_pin_in,   // Sync pin level as input
	input  wire logic        stat0_pin_in,  // Status 0 pin as input
	input  wire logic        stat1_pin_in,  // Status 1 pin as input
	input  wire logic        loop1_lock,    // Loop one digital lock
	input  wire logic        loop2_lock,    // Loop two digital lock
	input  wire logic        qual_clk_run,  // Qualifying output clock running
	input  wire logic [2:0]  ref_activity,  // Edge seen on each reference
	output logic      [5:0]  grp_sync,      // Per-group sync hold
	output logic             sync_pin_out,  // Sync pin drive
	output logic             lock_pin_out,  // Lock pin drive
	output logic             stat0_pin_out, // Status 0 pin drive
	output logic             stat1_pin_out, // Status 1 pin drive
	output logic             holdover,      // Holdover active
	output logic      [1:0]  ref_sel,       // Chosen reference input
	output logic      [2:0]  ref_lost,      // Loss of signal per input
	output logic             track_en,      // Tuning DAC tracks loop one
	output logic             xtal_en,       // Crystal oscillator on
	output logic             irq            // Level interrupt
);

	logic [31:0] sync_mode_r, lock_hold_r, hold_sel_r, loss_r;
	logic [cfg_regs_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r;
	cfg_regs_pkg::cfg_t cfg;
	cfg_regs_pkg::pins_t pins_nxt;
	logic [5:0]  grp_sync_r;
	logic        sync_busy_r, holdover_r, lock1_d_r, irq_r;
	logic [7:0]  loss_cnt_r [3];
	logic [2:0]  ref_lost_r;
	logic [1:0]  ref_sel_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;
	logic [6:0]  out_pins_r;

	// Bus decode; access answered in the access cycle one edge later
	wire         acc      = psel && penable && !pready_r;
	wire [7:0]   idx      = paddr[9:2];
	wire         wr       = acc && pwrite;
	wire         rd       = acc && !pwrite;
	wire         hit_ctl0 = idx == cfg_regs_pkg::IDX_CTRL0;
	wire         hit_sm   = idx == cfg_regs_pkg::IDX_SYNC_MODE;
	wire         hit_lh   = idx == cfg_regs_pkg::IDX_LOCK_HOLD;
	wire         hit_hs   = idx == cfg_regs_pkg::IDX_HOLD_SEL;
	wire         hit_ls   = idx == cfg_regs_pkg::IDX_LOSS;
	wire         hit_is   = idx == cfg_regs_pkg::IDX_IRQ_STAT;
	wire         hit_im   = idx == cfg_regs_pkg::IDX_IRQ_MASK;
	wire         hit_sc   = idx == cfg_regs_pkg::IDX_SYNC_CMD;
	wire         hit_st   = idx == cfg_regs_pkg::IDX_STATE;
	wire         hit_grp  = idx <= 8'h05;
	wire         mapped   = hit_grp || hit_sm || hit_lh || hit_hs || hit_ls
	                     || hit_is || hit_im || hit_sc || hit_st;
	wire         soft_rst = wr && hit_ctl0 && pwdata[cfg_regs_pkg::POS_SOFT_RESET];
	wire         rst_all  = sys_rst || soft_rst;

	// Field view of the stored words
	assign cfg.grp_excl     = sync_mode_r[cfg_regs_pkg::POS_GRP_EXCL_LO +: 6];
	assign cfg.sync_out_sel = sync_mode_r[cfg_regs_pkg::POS_SYNC_OUT_SEL +: 2];
	assign cfg.sync_qualify_enable    = sync_mode_r[cfg_regs_pkg::POS_SYNC_QUALIFY_ENABLE];
	assign cfg.sync_pol     = sync_mode_r[cfg_regs_pkg::POS_SYNC_POL];
	assign cfg.sync_auto    = sync_mode_r[cfg_regs_pkg::POS_SYNC_AUTO];
	assign cfg.xtal_en      = sync_mode_r[cfg_regs_pkg::POS_XTAL_EN];
	assign cfg.lock_sel     = lock_hold_r[cfg_regs_pkg::POS_LOCK_SEL +: 5];
	assign cfg.hold_l2      = lock_hold_r[cfg_regs_pkg::POS_HOLD_L2];
	assign cfg.hold_l1      = lock_hold_r[cfg_regs_pkg::POS_HOLD_L1];
	assign cfg.track_en     = lock_hold_r[cfg_regs_pkg::POS_TRACK];
	assign cfg.hold_mode    = lock_hold_r[cfg_regs_pkg::POS_HOLD_MODE +: 2];
	assign cfg.stat1_sel    = hold_sel_r[cfg_regs_pkg::POS_STAT1_SEL +: 3];
	assign cfg.edge_ign     = hold_sel_r[cfg_regs_pkg::POS_EDGE_IGN];
	assign cfg.stat0_sel    = hold_sel_r[cfg_regs_pkg::POS_STAT0_SEL +: 3];
	assign cfg.ref_mode     = hold_sel_r[cfg_regs_pkg::POS_REF_MODE +: 3];
	assign cfg.stat_inv     = hold_sel_r[cfg_regs_pkg::POS_STAT_INV];
	assign cfg.ref_usable   = hold_sel_r[cfg_regs_pkg::POS_REF_USE_LO +: 3];
	assign cfg.loss_to      = loss_r[cfg_regs_pkg::POS_LOSS_TO +: 2];

	// Sync sources: pin pulse, command register, or group writes when automatic
	wire sync_pin_act = sync_pin_in ^ cfg.sync_pol;
	wire grp_wr_sync  = wr && hit_grp && cfg.sync_auto;
	wire cmd_sync     = wr && hit_sc && pwdata[0];
	wire sync_req     = sync_pin_act || grp_wr_sync || cmd_sync;
	wire qual_ok      = !cfg.sync_qualify_enable || qual_clk_run;
	wire lock_hold    = (cfg.hold_l1 && !loop1_lock)
	                 || (cfg.hold_l2 && !loop2_lock);
	wire sync_stay    = (sync_req || lock_hold) && qual_ok;
	wire sync_done    = sync_busy_r && !sync_stay;

	// Loop one lock loss; the falling edge may be ignored
	wire lock1_fall   = lock1_d_r && !loop1_lock && !cfg.edge_ign;
	wire hold_en      = cfg.hold_mode == cfg_regs_pkg::HOLD_MODE_EN;
	wire any_usable_lost = |(ref_lost_r & cfg.ref_usable);
	wire hold_enter   = hold_en && !holdover_r && (lock1_fall || any_usable_lost);
	wire hold_exit    = holdover_r && loop1_lock && !any_usable_lost;

	// Loss timeout in cycles, rounded up
	wire [7:0] loss_lim = (cfg.loss_to == 2'h0) ? cfg_regs_pkg::LOSS_C0 :
	                      (cfg.loss_to == 2'h1) ? cfg_regs_pkg::LOSS_C1 :
	                      (cfg.loss_to == 2'h2) ? cfg_regs_pkg::LOSS_C2 :
	                                              cfg_regs_pkg::LOSS_C3;

	// Manual mode keeps the current input until it is lost or unusable; other modes take the lowest usable input not lost, else keep the current one
	wire [1:0] ref_pick = cfg.ref_usable[0] && !ref_lost_r[0] ? 2'h0 :
	                      cfg.ref_usable[1] && !ref_lost_r[1] ? 2'h1 :
	                      cfg.ref_usable[2] && !ref_lost_r[2] ? 2'h2 : ref_sel_r;
	wire       ref_keep = cfg.ref_mode == 3'h3 && cfg.ref_usable[ref_sel_r];

	wire [cfg_regs_pkg::IRQ_W-1:0] irq_ev = {any_usable_lost, hold_enter, sync_done};
	wire [cfg_regs_pkg::IRQ_W-1:0] irq_w1c = (wr && hit_is) ?
	                                         pwdata[cfg_regs_pkg::IRQ_W-1:0] : '0;

	// Status inputs with optional inversion feed the lock pin choices
	wire st0 = stat0_pin_in ^ cfg.stat_inv;
	wire st1 = stat1_pin_in ^ cfg.stat_inv;

	// Pin multiplexers; code 0 of every selector drives low
	always_comb begin
		unique case (cfg.sync_out_sel)
			2'h1:    pins_nxt.sync_pin = sync_busy_r;
			2'h2:    pins_nxt.sync_pin = holdover_r;
			2'h3:    pins_nxt.sync_pin = 1'b1;
			default: pins_nxt.sync_pin = 1'b0;
		endcase
		unique case (cfg.lock_sel)
			5'h01:   pins_nxt.lock_pin = loop1_lock;
			5'h02:   pins_nxt.lock_pin = loop2_lock;
			5'h03:   pins_nxt.lock_pin = loop1_lock && loop2_lock;
			5'h04:   pins_nxt.lock_pin = holdover_r;
			5'h05:   pins_nxt.lock_pin = st0 || st1;
			default: pins_nxt.lock_pin = 1'b0;
		endcase
		unique case (cfg.stat0_sel)
			3'h1:    pins_nxt.stat0_pin = 1'b1;
			3'h2:    pins_nxt.stat0_pin = loop1_lock;
			3'h3:    pins_nxt.stat0_pin = ref_lost_r[0];
			3'h4:    pins_nxt.stat0_pin = holdover_r;
			default: pins_nxt.stat0_pin = 1'b0;
		endcase
		unique case (cfg.stat1_sel)
			3'h1:    pins_nxt.stat1_pin = 1'b1;
			3'h2:    pins_nxt.stat1_pin = loop2_lock;
			3'h3:    pins_nxt.stat1_pin = ref_lost_r[1];
			3'h4:    pins_nxt.stat1_pin = holdover_r;
			default: pins_nxt.stat1_pin = 1'b0;
		endcase
	end

	// Read mux; read-only config bits read their reset values, other padding reads zero
	wire [31:0] rd_val =
		hit_sm ? sync_mode_r :
		hit_lh ? lock_hold_r :
		hit_hs ? hold_sel_r :
		hit_ls ? loss_r :
		hit_is ? {29'h0, irq_stat_r} :
		hit_im ? {29'h0, irq_mask_r} :
		hit_st ? {24'h0, ref_lost_r, ref_sel_r, holdover_r, sync_busy_r, 1'b0} :
		32'h0000_0000;

	// Configuration words; defaults on either reset, read-only bits kept on write
	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			sync_mode_r <= cfg_regs_pkg::RST_SYNC_MODE;
			lock_hold_r <= cfg_regs_pkg::RST_LOCK_HOLD;
			hold_sel_r  <= cfg_regs_pkg::RST_HOLD_SEL;
			loss_r      <= cfg_regs_pkg::RST_LOSS;
		end else if (wr) begin
			if (hit_sm)
				sync_mode_r <= sync_mode_r ^ ((sync_mode_r ^ pwdata) & cfg_regs_pkg::WM_SYNC_MODE);
			if (hit_lh)
				lock_hold_r <= lock_hold_r ^ ((lock_hold_r ^ pwdata) & cfg_regs_pkg::WM_LOCK_HOLD);
			if (hit_hs)
				hold_sel_r <= hold_sel_r ^ ((hold_sel_r ^ pwdata) & cfg_regs_pkg::WM_HOLD_SEL);
			if (hit_ls)
				loss_r <= loss_r ^ ((loss_r ^ pwdata) & cfg_regs_pkg::WM_LOSS);
		end
	end

	// Interrupt status: a new event beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_r      <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_ev;
			if (wr && hit_im)
				irq_mask_r <= pwdata[cfg_regs_pkg::IRQ_W-1:0];
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Sync event: excluded groups keep running
	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			sync_busy_r <= 1'b0;
			grp_sync_r  <= '0;
		end else begin
			sync_busy_r <= sync_stay;
			grp_sync_r  <= sync_stay ? ~cfg.grp_excl : 6'h00;
		end
	end

	// Holdover state and lock edge tracking
	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			holdover_r <= 1'b0;
			lock1_d_r  <= 1'b0;
		end else begin
			lock1_d_r <= loop1_lock;
			if (!hold_en || hold_exit)
				holdover_r <= 1'b0;
			else if (hold_enter)
				holdover_r <= 1'b1;
		end
	end

	// Per-input inactivity counters
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_loss
			always_ff @(posedge core_clk) begin
				if (rst_all || ref_activity[gi]) begin
					loss_cnt_r[gi] <= 8'h00;
					ref_lost_r[gi] <= 1'b0;
				end else if (loss_cnt_r[gi] >= loss_lim) begin
					ref_lost_r[gi] <= 1'b1;
				end else begin
					loss_cnt_r[gi] <= loss_cnt_r[gi] + 8'h01;
				end
			end
		end
	endgenerate

	// Reference choice
	always_ff @(posedge core_clk) begin
		if (rst_all)
			ref_sel_r <= 2'h0;
		else if (!ref_keep || ref_lost_r[ref_sel_r])
			ref_sel_r <= ref_pick;
	end

	// Bus answer and registered pin outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			out_pins_r <= 7'h00;
		end else begin
			pready_r   <= psel && penable && !pready_r;
			pslverr_r  <= acc && !mapped;
			prdata_r   <= rd ? rd_val : 32'h0000_0000;
			out_pins_r <= {pins_nxt, cfg.track_en, cfg.xtal_en, 1'b0};
		end
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign sync_pin_out  = out_pins_r[6];
	assign lock_pin_out  = out_pins_r[5];
	assign stat0_pin_out = out_pins_r[4];
	assign stat1_pin_out = out_pins_r[3];
	assign track_en      = out_pins_r[2];
	assign xtal_en       = out_pins_r[1];
	assign grp_sync      = grp_sync_r;
	assign holdover      = holdover_r;
	assign ref_sel       = ref_sel_r;
	assign ref_lost      = ref_lost_r;
	assign irq           = irq_r;

endmodule

// *** test/sync_holdover_mode_ctrl_regs_chk.sv ***
// Checker: bus timing, reset outputs, lock pin and loss timing.
// Assumes binding to the register bank top and sees its ports only.
module sync_holdover_mode_ctrl_regs_chk (
	input wire logic        core_clk,     // Clock
	input wire logic        sys_rst,      // Reset, high
	input wire logic        psel,         // Select
	input wire logic        penable,      // Access
	input wire logic        pwrite,       // Write
	input wire logic [9:0]  paddr,        // Address
	input wire logic [31:0] pwdata,       // Write data
	input wire logic [31:0] prdata,       // Read data
	input wire logic        pready,       // Ready
	input wire logic        pslverr,      // Error
	input wire logic        loop1_lock,   // Loop one lock
	input wire logic        loop2_lock,   // Loop two lock
	input wire logic [2:0]  ref_activity, // Reference edges
	input wire logic [5:0]  grp_sync,     // Group sync
	input wire logic        sync_pin_out, // Sync drive
	input wire logic        lock_pin_out, // Lock drive
	input wire logic        holdover,     // Holdover
	input wire logic [2:0]  ref_lost,     // Loss flags
	input wire logic        track_en,     // Tracking
	input wire logic        xtal_en       // Oscillator
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Lock selector known to be 3; a missed soft reset only narrows the check
	logic       lock_dflt_r;
	logic       lock_dflt_nxt;
	logic [7:0] quiet_r;
	logic [7:0] quiet_nxt;
	wire        lock_wr = psel & penable & pwrite & ~pready
		& (paddr == {cfg_regs_pkg::IDX_LOCK_HOLD, 2'b00});
	assign lock_dflt_nxt = lock_wr ? (pwdata[31:27] == 5'h03) : lock_dflt_r;
	assign quiet_nxt = ref_activity[0] ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};

	// Saturating count of quiet cycles on input 0
	always_ff @(posedge core_clk) begin
		lock_dflt_r <= sys_rst ? 1'b1 : lock_dflt_nxt;
		quiet_r     <= sys_rst ? 8'h00 : quiet_nxt;
	end

	property p_ready_wait; psel && penable && !pready |=> pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error with data");
	property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("stray read data");
	property p_rst_out;
		$fell(sys_rst) |-> !xtal_en && !holdover && ref_lost == 3'h0 && grp_sync == 6'h00
			&& !sync_pin_out;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("output not cleared");
	property p_rst_track; $fell(sys_rst) |=> track_en; endproperty
	a_rst_track: assert property (p_rst_track) else $error("tracking off");
	property p_lock_pin;
		lock_dflt_r && $past(lock_dflt_r) && !$past(sys_rst)
			|-> lock_pin_out == $past(loop1_lock & loop2_lock);
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");
	property p_loss_late; ref_lost[0] |-> quiet_r >= 8'd4; endproperty
	a_loss_late: assert property (p_loss_late) else $error("loss too early");

	c_err: cover property (pslverr);
	c_lost: cover property (ref_lost[0]);
	c_hold: cover property (holdover);
	c_sync: cover property (grp_sync != 6'h00);
endmodule

bind sync_holdover_mode_ctrl_regs sync_holdover_mode_ctrl_regs_chk u_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .loop1_lock(loop1_lock), .loop2_lock(loop2_lock),
	.ref_activity(ref_activity), .grp_sync(grp_sync), .sync_pin_out(sync_pin_out),
	.lock_pin_out(lock_pin_out), .holdover(holdover), .ref_lost(ref_lost),
	.track_en(track_en), .xtal_en(xtal_en));

// *** test/sync_holdover_mode_ctrl_regs_tb.sv ***
// Bench: register model, reset defaults, sync, interrupt, loss, holdover.
// Assumes the checker is bound to the design from its own file.
module sync_holdover_mode_ctrl_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [9:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, mdl[4];
	logic        pready, pslverr, sync_pin_in = 1, loop1_lock = 1, loop2_lock = 1, qual_run = 1;
	logic [2:0]  ref_activity = 3'h7, ref_lost;
	logic [5:0]  grp_sync;
	logic [1:0]  ref_sel;
	logic        sync_pin_out, lock_pin_out, s0_out, s1_out, holdover, track_en, xtal_en, irq;
	int          n_mismatch = 0, check_count = 0, i, n;
	logic [7:0]  ridx[4] = '{cfg_regs_pkg::IDX_SYNC_MODE, cfg_regs_pkg::IDX_LOCK_HOLD,
		cfg_regs_pkg::IDX_HOLD_SEL, cfg_regs_pkg::IDX_LOSS};
	logic [31:0] wm[4] = '{cfg_regs_pkg::WM_SYNC_MODE, cfg_regs_pkg::WM_LOCK_HOLD,
		cfg_regs_pkg::WM_HOLD_SEL, cfg_regs_pkg::WM_LOSS};
	// Documented defaults: register slot, low bit, width, value
	int          f_r[18] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3};
	int          f_lo[18] = '{20, 18, 17, 16, 15, 5, 27, 23, 22, 8, 6, 20, 12, 15, 9, 8, 5, 30};
	int          f_w[18] = '{6, 2, 1, 1, 1, 1, 5, 1, 1, 1, 2, 3, 3, 1, 3, 1, 3, 2};
	int          f_v[18] = '{24, 0, 0, 1, 0, 0, 3, 0, 0, 1, 2, 0, 0, 0, 3, 0, 7, 0};

	always #4 core_clk = ~core_clk;

	sync_holdover_mode_ctrl_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_pin_in(sync_pin_in), .stat0_pin_in(1'b0),
		.stat1_pin_in(1'b0), .loop1_lock(loop1_lock), .loop2_lock(loop2_lock),
		.qual_clk_run(qual_run), .ref_activity(ref_activity), .grp_sync(grp_sync),
		.sync_pin_out(sync_pin_out), .lock_pin_out(lock_pin_out), .stat0_pin_out(s0_out),
		.stat1_pin_out(s1_out), .holdover(holdover), .ref_sel(ref_sel), .ref_lost(ref_lost),
		.track_en(track_en), .xtal_en(xtal_en), .irq(irq));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; waits up to 16 cycles for the slave, then stops the run
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_mismatch++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(int k, logic [31:0] d);
		apb(1'b1, ridx[k], d);
		mdl[k] = (mdl[k] & ~wm[k]) | (d & wm[k]);
	endtask

	task automatic cmp_regs();
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, ridx[k], 32'h0);
			check("config word", rd, mdl[k]);
		end
	endtask

	// Bounded wait for holdover to reach a level
	task automatic wait_hold(logic v);
		for (int k = 0; k < 40 && holdover !== v; k++)
			@(posedge core_clk);
		check("holdover", holdover, v);
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		mdl = '{cfg_regs_pkg::RST_SYNC_MODE, cfg_regs_pkg::RST_LOCK_HOLD,
			cfg_regs_pkg::RST_HOLD_SEL, cfg_regs_pkg::RST_LOSS};
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		void'($urandom(25));
		cmp_regs();
		for (i = 0; i < 18; i++) begin
			apb(1'b0, ridx[f_r[i]], 32'h0);
			check("default field", (rd >> f_lo[i]) & ((1 << f_w[i]) - 1), f_v[i]);
		end
		check("track_en", track_en, 1);
		check("xtal_en", xtal_en, 0);
		check("pins low", {sync_pin_out, s0_out, s1_out}, 0);
		$display("test defaults done");
		for (i = 0; i < 12; i++)
			wr_reg(i % 4, $urandom);
		cmp_regs();
		repeat (2) @(posedge core_clk);
		check("xtal_en", xtal_en, mdl[0][5]);
		check("track_en", track_en, mdl[1][8]);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped err", err, 1);
		check("unmapped data", rd, 0);
		apb(1'b1, cfg_regs_pkg::IDX_CTRL0, 32'h0002_0000);
		mdl = '{cfg_regs_pkg::RST_SYNC_MODE, cfg_regs_pkg::RST_LOCK_HOLD,
			cfg_regs_pkg::RST_HOLD_SEL, cfg_regs_pkg::RST_LOSS};
		cmp_regs();
		apb(1'b0, cfg_regs_pkg::IDX_CTRL0, 32'h0);
		check("index 0 err", err, 0);
		check("index 0 data", rd, 0);
		$display("test registers done");
		apb(1'b1, 8'h01, $urandom);
		repeat (4) @(posedge core_clk);
		check("no auto sync", grp_sync, 0);
		sync_pin_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("sync groups", grp_sync, 6'h27);
		sync_pin_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("sync ended", grp_sync, 0);
		wr_reg(0, cfg_regs_pkg::RST_SYNC_MODE | 32'h0002_8000);
		apb(1'b1, 8'h02, 32'h0);
		check("auto sync", grp_sync, 6'h27);
		qual_run <= 1'b0;
		sync_pin_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("unqualified", grp_sync, 0);
		qual_run <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("qualified", grp_sync, 6'h27);
		sync_pin_in <= 1'b1;
		wr_reg(0, cfg_regs_pkg::RST_SYNC_MODE);
		wr_reg(1, cfg_regs_pkg::RST_LOCK_HOLD | 32'h0080_0000);
		loop2_lock <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("loop2 hold", grp_sync, 6'h27);
		loop2_lock <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("loop2 free", grp_sync, 0);
		wr_reg(1, cfg_regs_pkg::RST_LOCK_HOLD);
		apb(1'b0, cfg_regs_pkg::IDX_IRQ_STAT, 32'h0);
		check("sync done", {irq, rd[0]}, 2'b01);
		apb(1'b1, cfg_regs_pkg::IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge core_clk);
		check("irq on", irq, 1);
		apb(1'b1, cfg_regs_pkg::IDX_IRQ_STAT, 32'h1);
		repeat (2) @(posedge core_clk);
		check("irq off", irq, 0);
		$display("test sync done");
		ref_activity <= 3'h6;
		repeat (140) @(posedge core_clk);
		check("not lost yet", ref_lost, 0);
		repeat (20) @(posedge core_clk);
		check("lost", ref_lost, 3'h1);
		wait_hold(1'b1);
		ref_activity <= 3'h7;
		wait_hold(1'b0);
		wr_reg(2, cfg_regs_pkg::RST_HOLD_SEL & ~32'h20);
		ref_activity <= 3'h6;
		repeat (170) @(posedge core_clk);
		check("unusable loss", holdover, 0);
		check("ref_sel", ref_sel, 2'h1);
		ref_activity <= 3'h7;
		$display("test loss done");
		wr_reg(2, cfg_regs_pkg::RST_HOLD_SEL | 32'h8000);
		repeat (4) @(posedge core_clk);
		loop1_lock <= 1'b0;
		repeat (10) @(posedge core_clk);
		check("edge ignored", holdover, 0);
		loop1_lock <= 1'b1;
		wr_reg(2, cfg_regs_pkg::RST_HOLD_SEL);
		repeat (4) @(posedge core_clk);
		loop1_lock <= 1'b0;
		wait_hold(1'b1);
		loop1_lock <= 1'b1;
		wait_hold(1'b0);
		wr_reg(1, 32'h2800_0180);
		repeat (2) @(posedge core_clk);
		check("status high", lock_pin_out, 0);
		wr_reg(2, cfg_regs_pkg::RST_HOLD_SEL | 32'h0000_0100);
		repeat (2) @(posedge core_clk);
		check("status invert", lock_pin_out, 1);
		$display("test holdover done");
		report_and_stop();
	end
endmodule
